//--- pim_pkg.sv
// constants shared by the priority interrupt controller files
package pim_pkg;
  localparam int unsigned NUM_INPUTS     = 8;
  localparam int unsigned LEVEL_W        = 3;
  localparam int unsigned BASE_W         = 5;
  // address bit values
  localparam logic        ADDR_CMD       = 1'b0;
  localparam logic        ADDR_MASK      = 1'b1;
  // command word selection bits
  localparam int unsigned SEL_HI_BIT     = 4;
  localparam int unsigned SEL_LO_BIT     = 3;
  // rotate_eoi_command fields
  localparam int unsigned ROTATE_BIT     = 7;
  localparam int unsigned SELECT_LVL_BIT = 6;
  localparam int unsigned EOS_BIT        = 5;
  localparam int unsigned LEVEL_LSB      = 0;
  // mask_poll_read_command fields
  localparam int unsigned SM_ENABLE_BIT  = 6;
  localparam int unsigned SM_SELECT_BIT  = 5;
  localparam int unsigned POLL_BIT       = 2;
  localparam int unsigned RD_ENABLE_BIT  = 1;
  localparam int unsigned RD_ISR_BIT     = 0;
  // poll answer layout
  localparam int unsigned POLL_FLAG_BIT  = 7;
  // reset values and the no-request level code
  localparam logic [2:0]  PRIO_LOW_RESET = 3'h7;
  localparam logic [2:0]  NO_REQ_LEVEL   = 3'h7;
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  localparam logic [7:0]  ISR_RESET      = 8'h00;
  localparam logic [2:0]  CASCADE_IDLE   = 3'h0;

  typedef enum logic [0:0]
  {
    PIM_ACK_IDLE = 1'b0,
    PIM_ACK_WAIT = 1'b1
  } pim_ack_state_type;
endpackage

//--- pim_resolver.sv
// rotating priority resolver: highest priority set bit of a vector
`timescale 1ns/100ps
module pim_resolver
  import pim_pkg::*;
(
  input  wire logic [7:0] vec_i,
  input  wire logic [2:0] low_i,
  output logic            found_o,
  output logic [2:0]      idx_o
);
  logic [7:0] rot;
  logic [2:0] pos;
  logic [2:0] top;

  // input low_i+1 is the highest priority
  assign top = 3'(low_i + 3'h1);
  assign rot = (vec_i >> top) | (vec_i << (4'h8 - {1'b0, top}));

  always_comb
  begin
    pos = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (rot[i])
      begin
        pos = 3'(i);
      end
    end
  end

  assign found_o = |vec_i;
  assign idx_o   = 3'(pos + top);
endmodule

//--- pim_request_cell.sv
// one request latch cell with edge or level capture
`timescale 1ns/100ps
module pim_request_cell
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic level_i,
  input  wire logic level_mode_i,
  input  wire logic clear_i,
  input  wire logic rearm_i,
  output logic      latch_o
);
  logic prev_q;
  logic latch_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_q <= 1'b1;
    end
    else
    begin
      // rearm demands a fresh rising edge
      prev_q <= rearm_i ? 1'b1 : level_i;
    end
  end

  // a new edge beats a clear in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      latch_q <= 1'b0;
    end
    else if (rearm_i)
    begin
      latch_q <= 1'b0;
    end
    else if (level_i && (level_mode_i || !prev_q))
    begin
      latch_q <= 1'b1;
    end
    else if (!level_i || clear_i)
    begin
      latch_q <= 1'b0;
    end
  end

  assign latch_o = latch_q;
endmodule

//--- pim_controller.sv
// eight-input priority interrupt controller: commands, modes, acknowledge
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
module pim_controller
  import pim_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  output logic                       rdata_valid_o,
  input  wire logic                  ack_i,
  output logic      [7:0]            vector_o,
  output logic                       vector_valid_o,
  input  wire logic [7:0]            request_inputs_i,
  output logic                       interrupt_o,
  output logic      [2:0]            cascade_lines_o,
  output logic                       cascade_lines_oe_n_o,
  output logic                       slave_program_buffer_enable_n_o,
  input  wire logic                  cfg_level_trigger_i,
  input  wire logic                  cfg_auto_eos_i,
  input  wire logic                  cfg_special_nesting_i,
  input  wire logic                  cfg_buffered_i,
  input  wire logic                  cfg_master_i,
  input  wire logic [7:0]            cfg_slave_map_i,
  input  wire logic [BASE_W-1:0]     cfg_vector_base_i
);
  import pim_pkg::*;

  pim_ack_state_type ack_state_q;
  logic [7:0] req_meta_q;
  logic [7:0] req_sync_q;
  logic [7:0] request_latch;
  logic [7:0] imr_q;
  logic [7:0] isr_q;
  logic [7:0] isr_set;
  logic [7:0] isr_clr;
  logic [7:0] irr_clr;
  logic [7:0] isr_eff;
  logic [7:0] req_vec;
  logic [2:0] prio_low_q;
  logic       smm_q;
  logic       sel_isr_q;
  logic       rot_aeos_q;
  logic       poll_q;
  logic       poll_pend_q;
  logic [2:0] poll_lvl_q;
  logic       ack_found_q;
  logic [2:0] ack_lvl_q;
  logic [7:0] rdata_q;
  logic       rd_valid_q;
  logic [7:0] vector_q;
  logic       vec_valid_q;
  logic [2:0] cascade_q;
  logic       int_q;
  logic       req_found;
  logic [2:0] req_idx;
  logic       isr_found;
  logic [2:0] isr_idx;
  logic       grant;
  logic       wr_cmd;
  logic       wr_mask;
  logic       is_rot;
  logic       is_mpr;
  logic       is_init;
  logic       ack_first;
  logic       ack_final;
  logic       poll_rd;
  logic       ns_eos;
  logic       sp_eos;
  logic [2:0] lvl_field;

  function automatic logic [2:0] rank(input logic [2:0] idx,
                                      input logic [2:0] low);
    rank = 3'(idx - low - 3'h1);
  endfunction

  // request pins come from outside the clock domain
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      req_meta_q <= 8'h00;
      req_sync_q <= 8'h00;
    end
    else
    begin
      req_meta_q <= request_inputs_i;
      req_sync_q <= req_meta_q;
    end
  end

  assign wr_cmd  = wr_i && (addr_i == ADDR_CMD);
  assign is_rot  = wr_cmd && !wdata_i[SEL_HI_BIT] && !wdata_i[SEL_LO_BIT];
  assign is_mpr  = wr_cmd && !wdata_i[SEL_HI_BIT] && wdata_i[SEL_LO_BIT];
  assign is_init = wr_cmd && wdata_i[SEL_HI_BIT];
  // address high is always a mask write
  assign wr_mask = wr_i && (addr_i == ADDR_MASK);
  // level field read only by specific operations
  assign lvl_field = wdata_i[LEVEL_LSB +: LEVEL_W];
  assign ns_eos  = is_rot && wdata_i[EOS_BIT] && !wdata_i[SELECT_LVL_BIT];
  assign sp_eos  = is_rot && wdata_i[EOS_BIT] && wdata_i[SELECT_LVL_BIT];
  assign ack_first = ack_i && (ack_state_q == PIM_ACK_IDLE);
  assign ack_final = ack_i && (ack_state_q == PIM_ACK_WAIT);
  assign poll_rd   = rd_i && poll_q;

  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g++)
    begin : g_cell
      // edge or level capture per input
      pim_request_cell u_cell
      (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .level_i      (req_sync_q[g]),
        .level_mode_i (cfg_level_trigger_i),
        .clear_i      (irr_clr[g]),
        .rearm_i      (is_init),
        .latch_o      (request_latch[g])
      );
    end
  endgenerate

  assign req_vec = request_latch & ~imr_q;
  // special mask hides masked in-service bits
  assign isr_eff = smm_q ? (isr_q & ~imr_q) : isr_q;

  pim_resolver u_req_res
  (
    .vec_i   (req_vec),
    .low_i   (prio_low_q),
    .found_o (req_found),
    .idx_o   (req_idx)
  );

  pim_resolver u_isr_res
  (
    .vec_i   (isr_eff),
    .low_i   (prio_low_q),
    .found_o (isr_found),
    .idx_o   (isr_idx)
  );

  // lower requests ignored while a higher one is in service
  // special nesting lets the serving slave through again
  assign grant = req_found &&
                 (!isr_found ||
                  (rank(req_idx, prio_low_q) < rank(isr_idx, prio_low_q)) ||
                  (cfg_special_nesting_i && cfg_master_i &&
                   cfg_slave_map_i[req_idx] && (req_idx == isr_idx)));

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      int_q <= 1'b0;
    end
    else
    begin
      int_q <= grant && (ack_state_q == PIM_ACK_IDLE) && !poll_q;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      imr_q <= MASK_RESET;
    end
    else if (wr_mask)
    begin
      imr_q <= wdata_i;
    end
    else if (is_init)
    begin
      imr_q <= MASK_RESET;
    end
  end

  // special mask and read selection persist between writes
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      smm_q     <= 1'b0;
      sel_isr_q <= 1'b0;
    end
    else if (is_init)
    begin
      smm_q     <= 1'b0;
      sel_isr_q <= 1'b0;
    end
    else if (is_mpr)
    begin
      if (wdata_i[SM_ENABLE_BIT])
      begin
        smm_q <= wdata_i[SM_SELECT_BIT];
      end
      if (wdata_i[RD_ENABLE_BIT])
      begin
        sel_isr_q <= wdata_i[RD_ISR_BIT];
      end
    end
  end

  // poll freezes the answer at the write, ends at the next read
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      poll_q      <= 1'b0;
      poll_pend_q <= 1'b0;
      poll_lvl_q  <= 3'h0;
    end
    else if (is_mpr && wdata_i[POLL_BIT])
    begin
      poll_q      <= 1'b1;
      poll_pend_q <= grant;
      poll_lvl_q  <= grant ? req_idx : 3'h0;
    end
    else if (rd_i)
    begin
      poll_q <= 1'b0;
    end
  end

  // acknowledge sequence: first pulse picks, final pulse delivers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_state_q <= PIM_ACK_IDLE;
      ack_found_q <= 1'b0;
      ack_lvl_q   <= 3'h0;
    end
    else
    begin
      case (ack_state_q)
        PIM_ACK_IDLE:
        begin
          if (ack_first)
          begin
            ack_state_q <= PIM_ACK_WAIT;
            ack_found_q <= grant;
            ack_lvl_q   <= grant ? req_idx : NO_REQ_LEVEL;
          end
        end
        PIM_ACK_WAIT:
        begin
          if (ack_final)
          begin
            ack_state_q <= PIM_ACK_IDLE;
          end
        end
        default:
        begin
          ack_state_q <= PIM_ACK_IDLE;
        end
      endcase
    end
  end

  // set in service on delivery, also on a pending poll read
  // auto end-of-service means a delivery never leaves the bit set
  // nothing is set when the request vanished
  always_comb
  begin
    isr_set = 8'h00;
    irr_clr = 8'h00;
    if (ack_final && ack_found_q)
    begin
      irr_clr[ack_lvl_q] = 1'b1;
      isr_set[ack_lvl_q] = !cfg_auto_eos_i;
    end
    if (poll_rd && poll_pend_q)
    begin
      irr_clr[poll_lvl_q] = 1'b1;
      isr_set[poll_lvl_q] = 1'b1;
    end
  end

  // non-specific clears top in-service bit (masked bits skipped only in special mask), specific clears named
  always_comb
  begin
    isr_clr = 8'h00;
    if (ns_eos && isr_found)
    begin
      isr_clr[isr_idx] = 1'b1;
    end
    if (sp_eos)
    begin
      isr_clr[lvl_field] = 1'b1;
    end
  end

  // set beats clear in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      isr_q <= ISR_RESET;
    end
    else
    begin
      isr_q <= (isr_q & ~isr_clr) | isr_set;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rot_aeos_q <= 1'b0;
    end
    else if (is_rot && !wdata_i[EOS_BIT] && !wdata_i[SELECT_LVL_BIT])
    begin
      rot_aeos_q <= wdata_i[ROTATE_BIT];
    end
  end

  // serviced input becomes lowest, named input becomes lowest
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prio_low_q <= PRIO_LOW_RESET;
    end
    else if (is_init)
    begin
      prio_low_q <= PRIO_LOW_RESET;
    end
    else if (is_rot && wdata_i[ROTATE_BIT] && wdata_i[SELECT_LVL_BIT])
    begin
      prio_low_q <= lvl_field;
    end
    else if (ns_eos && wdata_i[ROTATE_BIT] && isr_found)
    begin
      prio_low_q <= isr_idx;
    end
    else if (ack_final && ack_found_q && cfg_auto_eos_i && rot_aeos_q)
    begin
      prio_low_q <= ack_lvl_q;
    end
  end

  // poll answer, status readback with poll taking precedence
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_q    <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_i;
      if (poll_rd)
      begin
        rdata_q <= {poll_pend_q, 4'h0, poll_lvl_q};
      end
      else if (rd_i && (addr_i == ADDR_MASK))
      begin
        rdata_q <= imr_q;
      end
      else if (rd_i)
      begin
        rdata_q <= sel_isr_q ? isr_q : request_latch;
      end
    end
  end

  // a vanished request answers with level code 7 (NO_REQ_LEVEL)
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vector_q    <= 8'h00;
      vec_valid_q <= 1'b0;
    end
    else
    begin
      vec_valid_q <= ack_final;
      if (ack_final)
      begin
        vector_q <= {cfg_vector_base_i, ack_lvl_q};
      end
    end
  end

  // slave id held from after first pulse until final pulse
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cascade_q <= CASCADE_IDLE;
    end
    else if (ack_first && grant && cfg_master_i && cfg_slave_map_i[req_idx])
    begin
      cascade_q <= req_idx;
    end
    else if (ack_final)
    begin
      cascade_q <= CASCADE_IDLE;
    end
  end

  assign rdata_o              = rdata_q;
  assign rdata_valid_o        = rd_valid_q;
  assign vector_o             = vector_q;
  assign vector_valid_o       = vec_valid_q;
  assign interrupt_o          = int_q;
  assign cascade_lines_o      = cascade_q;
  assign cascade_lines_oe_n_o = !cfg_master_i;
  // buffer enable follows the data drivers
  assign slave_program_buffer_enable_n_o =
    !(cfg_buffered_i && (rd_valid_q || vec_valid_q));

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_mask_write_load: assert property (wr_mask |=> imr_q == $past(wdata_i))
    else $error("mask write not loaded");
  a_poll_read_data: assert property (poll_rd |=> rdata_valid_o &&
    rdata_o == {$past(poll_pend_q), 4'h0, $past(poll_lvl_q)})
    else $error("poll answer wrong");
  a_isr_status_read: assert property ((rd_i && !addr_i && !poll_q &&
    sel_isr_q) |=> rdata_o == $past(isr_q))
    else $error("in-service readback wrong");
  a_ns_eos_clear: assert property ((ns_eos && isr_found && !ack_final &&
    !poll_rd) |=> !isr_q[$past(isr_idx)])
    else $error("non-specific end left bit set");
  a_spec_eos_clear: assert property ((sp_eos && !ack_final && !poll_rd)
    |=> !isr_q[$past(lvl_field)])
    else $error("specific end left bit set");
  a_spec_rotate: assert property ((is_rot && wdata_i[ROTATE_BIT] &&
    wdata_i[SELECT_LVL_BIT]) |=> prio_low_q == $past(lvl_field))
    else $error("specific rotation not applied");
  a_cascade_idle_low: assert property ((ack_state_q == PIM_ACK_IDLE)
    |-> cascade_lines_o == CASCADE_IDLE)
    else $error("cascade lines driven outside acknowledge");
  a_buffer_enable: assert property ((cfg_buffered_i && rd_i)
    |=> !slave_program_buffer_enable_n_o)
    else $error("buffer enable not low while driving");
  a_no_req_vector: assert property ((ack_final && !ack_found_q &&
    !wr_i && !poll_rd) |=> vector_o[2:0] == NO_REQ_LEVEL &&
    isr_q == $past(isr_q))
    else $error("missing request handled wrongly");
  a_auto_eos_clear: assert property ((ack_final && cfg_auto_eos_i &&
    !wr_i && !poll_rd) |=> isr_q == $past(isr_q))
    else $error("auto end left in-service bit");
  a_isr_set_ack: assert property ((ack_final && ack_found_q &&
    !cfg_auto_eos_i) |=> isr_q[$past(ack_lvl_q)] && vector_valid_o)
    else $error("acknowledge did not set in-service");
  a_int_blocked: assert property ((!grant) |=> !interrupt_o)
    else $error("interrupt without eligible request");

  c_full_ack: cover property (ack_first ##[1:20] ack_final);
  c_poll_pending: cover property (poll_rd && poll_pend_q);
  c_auto_rotate: cover property (ns_eos && wdata_i[ROTATE_BIT] && isr_found);
  c_special_mask: cover property (smm_q && grant && isr_q != 8'h00);
endmodule

//--- pim_host_model.sv
// host side model: command writes, status reads, acknowledge pulses
`timescale 1ns/100ps
module pim_host_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic [2:0] cascade_i,
  output logic            addr_o,
  output logic [7:0]      wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            ack_o
);
  initial
  begin
    addr_o = 1'b0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    ack_o = 1'b0;
  end

  task automatic write(input logic a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // released bus shows junk, not the last byte
    wdata_o <= ~d;
  endtask

  task automatic read(input logic a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask

  task automatic end_service();
    write(1'b0, 8'h20);
  endtask

  // first and final pulse; mid returns the cascade id in between
  task automatic ack_pair(output logic [2:0] mid);
    @(posedge clk_i);
    ack_o <= 1'b1;
    @(posedge clk_i);
    ack_o <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    mid = cascade_i;
    @(posedge clk_i);
    ack_o <= 1'b1;
    @(posedge clk_i);
    ack_o <= 1'b0;
  endtask
endmodule

//--- pim_controller_tb_top.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/100ps
module pim_controller_tb_top;
  import pim_pkg::*;
  localparam logic [4:0] BASE_V = 5'h15;
  logic       clk;
  logic       reset_n;
  logic [7:0] req;
  logic       lvl_mode;
  logic       auto_eos;
  logic       addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       ack;
  logic [7:0] rdata;
  logic [7:0] vec;
  logic       vvalid;
  logic       irq;
  logic [2:0] cas;
  logic       buf_n;
  logic       nesting;
  logic       rvalid;
  logic       cas_oe_n;
  logic [7:0] d;
  logic [2:0] mid;
  int         fail_count;
  int         samples_checked;

  pim_controller DUT (.clk_i(clk), .reset_n_i(reset_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .rdata_valid_o(rvalid), .ack_i(ack), .vector_o(vec),
    .vector_valid_o(vvalid), .request_inputs_i(req), .interrupt_o(irq),
    .cascade_lines_o(cas), .cascade_lines_oe_n_o(cas_oe_n),
    .slave_program_buffer_enable_n_o(buf_n),
    .cfg_level_trigger_i(lvl_mode), .cfg_auto_eos_i(auto_eos),
    .cfg_special_nesting_i(nesting), .cfg_buffered_i(1'b1),
    .cfg_master_i(1'b1), .cfg_slave_map_i(8'h04),
    .cfg_vector_base_i(BASE_V));

  pim_host_model host (.clk_i(clk), .rdata_i(rdata), .cascade_i(cas),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .ack_o(ack));

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // sync plus latch plus output register needs about four cycles
  task automatic see_irq(input logic exp);
    repeat (8) @(negedge clk);
    check("interrupt", {7'h00, irq}, {7'h00, exp});
  endtask

  task automatic ack_expect(input logic [2:0] lvl, input logic [2:0] id);
    host.ack_pair(mid);
    check("cascade id", {5'h00, mid}, {5'h00, id});
    @(negedge clk);
    check("vector", vec, {BASE_V, lvl});
    check("vector valid", {7'h00, vvalid}, 8'h01);
    check("buffer enable", {7'h00, buf_n}, 8'h00);
    check("cascade enable", {7'h00, cas_oe_n}, 8'h00);
  endtask

  task automatic read_isr(input logic [7:0] exp);
    host.write(ADDR_CMD, 8'h0b);
    host.read(ADDR_CMD, d);
    check("in service", d, exp);
    check("read valid", {7'h00, rvalid}, 8'h01);
  endtask

  task automatic t_nested;
    @(posedge clk);
    req <= 8'h60;
    see_irq(1'b1);
    ack_expect(3'h5, 3'h0);
    check("cascade idle", {5'h00, cas}, 8'h00);
    see_irq(1'b0);
    @(posedge clk);
    req <= 8'h64;
    see_irq(1'b1);
    ack_expect(3'h2, 3'h2);
    read_isr(8'h24);
    host.end_service();
    read_isr(8'h20);
    host.write(ADDR_CMD, 8'h65);
    read_isr(8'h00);
    see_irq(1'b1);
    ack_expect(3'h6, 3'h0);
    host.end_service();
    @(posedge clk);
    req <= 8'h00;
  endtask

  task automatic t_mask;
    host.write(ADDR_MASK, 8'h08);
    host.read(ADDR_MASK, d);
    check("mask", d, 8'h08);
    @(posedge clk);
    req <= 8'h08;
    see_irq(1'b0);
    host.write(ADDR_MASK, 8'h00);
    see_irq(1'b1);
    host.write(ADDR_CMD, 8'h0a);
    host.read(ADDR_CMD, d);
    check("request latch", d, 8'h08);
  endtask

  task automatic t_poll;
    host.write(ADDR_CMD, 8'h0c);
    host.read(ADDR_CMD, d);
    check("poll answer", d, 8'h83);
    read_isr(8'h08);
    host.write(ADDR_CMD, 8'h63);
    read_isr(8'h00);
    @(posedge clk);
    req <= 8'h00;
    host.write(ADDR_CMD, 8'h0c);
    host.read(ADDR_CMD, d);
    check("empty poll", d, 8'h00);
    // acknowledge with nothing pending answers as input 7
    ack_expect(3'h7, 3'h0);
    read_isr(8'h00);
  endtask

  task automatic t_auto_level;
    @(posedge clk);
    lvl_mode <= 1'b1;
    auto_eos <= 1'b1;
    req <= 8'h02;
    // rotate on every automatic end from now on
    host.write(ADDR_CMD, 8'h80);
    see_irq(1'b1);
    ack_expect(3'h1, 3'h0);
    read_isr(8'h00);
    see_irq(1'b1);
    @(posedge clk);
    req <= 8'h07;
    see_irq(1'b1);
    // input 1 went lowest, so input 2 leads now
    ack_expect(3'h2, 3'h2);
    // flop cleared: input 0 must lead twice in a row
    host.write(ADDR_CMD, 8'h00);
    ack_expect(3'h0, 3'h0);
    ack_expect(3'h0, 3'h0);
    @(posedge clk);
    req <= 8'h00;
    see_irq(1'b0);
    @(posedge clk);
    lvl_mode <= 1'b0;
    auto_eos <= 1'b0;
  endtask

  task automatic t_rotate;
    // lowest moves to input 3, so input 4 outranks input 2
    host.write(ADDR_CMD, 8'hc3);
    @(posedge clk);
    req <= 8'h14;
    see_irq(1'b1);
    ack_expect(3'h4, 3'h0);
    @(posedge clk);
    req <= 8'h04;
    host.write(ADDR_CMD, 8'ha0);
    read_isr(8'h00);
    @(posedge clk);
    req <= 8'h14;
    see_irq(1'b1);
    ack_expect(3'h2, 3'h2);
  endtask

  task automatic t_nesting;
    // slave on input 2 is still in service from the rotate scenario
    @(posedge clk);
    nesting <= 1'b1;
    req <= 8'h10;
    see_irq(1'b0);
    @(posedge clk);
    req <= 8'h14;
    see_irq(1'b1);
    ack_expect(3'h2, 3'h2);
    host.end_service();
    read_isr(8'h00);
    @(posedge clk);
    nesting <= 1'b0;
    req <= 8'h00;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    req = 8'h00;
    lvl_mode = 1'b0;
    auto_eos = 1'b0;
    nesting = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_nested();
    t_mask();
    t_poll();
    t_auto_level();
    t_rotate();
    t_nesting();
    end_of_test();
  end

  // whole run needs well under two thousand cycles
  initial
  begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule
